// [design/cbs_unit.sv]
// Conditional branch and skip unit: program counter update and cycle count
// Function
// - I/O bit set skips the next instruction in 1, 2 or 3 cycles.
// - Status bit set branch loads PC+k+1 when bit s is one.
// - Status bit clear branch loads PC+k+1 when bit s is zero.
// - Equal branch loads PC+k+1 when the zero flag is one.
// - Not-equal branch loads PC+k+1 when the zero flag is zero.
// - Carry-set and lower branches load PC+k+1 when carry is one.
// - Carry-clear and same-or-higher load PC+k+1 when carry is zero.
// - Minus branch loads PC+k+1 when negative is one, flags untouched.
// - Plus branch loads PC+k+1 when negative is zero, 1 or 2 cycles.
module cbs_unit
  import cbs_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Instruction issue
  input wire logic issue_i,
  input wire cbs_op_t op_i,
  input wire logic [2:0] sel_i,
  input wire logic [K_W-1:0] offset_i,
  input wire logic [IO_AW-1:0] io_addr_i,
  input wire logic skip_two_word_i,
  // Processor state read by the unit
  input wire logic [PC_W-1:0] pc_i,
  input wire logic [FLAG_W-1:0] flags_i,
  input wire logic [FLAG_W-1:0] io_data_i,
  input wire logic [2:0] io_bit_sel_i,
  // Results
  output logic [PC_W-1:0] pc_next_o,
  output logic pc_load_o,
  output logic [1:0] cycles_o,
  output logic taken_o,
  output logic busy_o,
  output logic [IO_AW-1:0] io_addr_o,
  output logic [FLAG_W-1:0] flags_o
);
  logic taken;
  logic is_branch;
  logic io_bit;
  logic [PC_W-1:0] pc_q, pc_d;
  logic load_q, load_d;
  logic [1:0] cyc_q, cyc_d;
  logic tk_q, tk_d;
  logic [1:0] wait_q, wait_d;
  logic [IO_AW-1:0] ioa_q, ioa_d;
  logic [FLAG_W-1:0] fl_q, fl_d;
  logic busy_q, busy_d;
  logic accept;

  // Sign extension of the word offset
  function automatic logic [PC_W-1:0] sext_k(input logic [K_W-1:0] k);
    sext_k = {{(PC_W-K_W){k[K_W-1]}}, k};
  endfunction : sext_k

  assign io_bit = io_data_i[io_bit_sel_i];

  // Illegal codes and issues during a stall are dropped silently
  assign accept = issue_i && !busy_q
    && (is_branch || op_i == CBS_OP_SKIP_IO_SET);

  cbs_cond_eval cbs_cond_eval_inst (
    .op_i(op_i),
    .sel_i(sel_i),
    .flags_i(flags_i),
    .io_bit_i(io_bit),
    .taken_o(taken),
    .is_branch_o(is_branch)
  );

  // Next program counter and cycle count; stall cycles block new issues
  always_comb begin
    pc_d = pc_q;
    load_d = 1'b0;
    cyc_d = cyc_q;
    tk_d = tk_q;
    wait_d = (wait_q != 2'h0) ? wait_q - 2'h1 : 2'h0;
    ioa_d = ioa_q;
    fl_d = flags_i; // Flags pass through, never written here
    if (accept) begin
      load_d = 1'b1;
      ioa_d = io_addr_i;
      tk_d = taken;
      if (is_branch) begin
        if (taken) begin
          pc_d = pc_i + sext_k(offset_i) + PC_ONE;
          cyc_d = CYC_TWO;
        end else begin
          pc_d = pc_i + PC_ONE;
          cyc_d = CYC_ONE;
        end
      end else if (taken) begin
        // One or two words skipped
        pc_d = pc_i + (skip_two_word_i ? PC_THREE : PC_TWO);
        cyc_d = skip_two_word_i ? CYC_THREE : CYC_TWO;
      end else begin
        pc_d = pc_i + PC_ONE;
        cyc_d = CYC_ONE;
      end
      wait_d = cyc_d - 2'h1;
    end
    busy_d = (wait_d != 2'h0); // Registered so busy_o is a flop
  end

  // State registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_q <= PC_RESET;
      load_q <= 1'b0;
      cyc_q <= 2'h0;
      tk_q <= 1'b0;
      wait_q <= 2'h0;
      ioa_q <= '0;
      fl_q <= '0;
      busy_q <= 1'b0;
    end else begin
      pc_q <= pc_d;
      load_q <= load_d;
      cyc_q <= cyc_d;
      tk_q <= tk_d;
      wait_q <= wait_d;
      ioa_q <= ioa_d;
      fl_q <= fl_d;
      busy_q <= busy_d;
    end
  end

  assign pc_next_o = pc_q;
  assign pc_load_o = load_q;
  assign cycles_o = cyc_q;
  assign taken_o = tk_q;
  assign busy_o = busy_q;
  assign io_addr_o = ioa_q;
  assign flags_o = fl_q;

  // Taken branch lands at PC+k+1 with two cycles
  a_branch_target: assert property (
    @(posedge clk_i) disable iff (rst_i)
    issue_i && !busy_o && is_branch && taken |=>
    pc_next_o == $past(pc_i) + sext_k($past(offset_i)) + PC_ONE
    && cycles_o == CYC_TWO)
    else $error("taken branch target or cycle count wrong");
  // Untaken branch falls through in one cycle
  a_branch_fall: assert property (
    @(posedge clk_i) disable iff (rst_i)
    issue_i && !busy_o && is_branch && !taken |=>
    pc_next_o == $past(pc_i) + PC_ONE && cycles_o == CYC_ONE && !busy_o)
    else $error("untaken branch did not fall through");
  // Taken branch stalls exactly one extra cycle
  a_branch_stall: assert property (
    @(posedge clk_i) disable iff (rst_i)
    issue_i && !busy_o && is_branch && taken |=> busy_o ##1 !busy_o)
    else $error("taken branch stall length wrong");
  // Status bit branches test the selected bit
  a_sbit_set: assert property (
    @(posedge clk_i) disable iff (rst_i)
    issue_i && !busy_o && op_i == CBS_OP_BR_SBIT_SET |=>
    taken_o == $past(flags_i[sel_i]))
    else $error("status bit set branch wrong sense");
  a_sbit_clear: assert property (
    @(posedge clk_i) disable iff (rst_i)
    issue_i && !busy_o && op_i == CBS_OP_BR_SBIT_CLR |=>
    taken_o != $past(flags_i[sel_i]))
    else $error("status bit clear branch wrong sense");
  // Equal branch follows zero flag
  a_equal_cond: assert property (
    @(posedge clk_i) disable iff (rst_i)
    issue_i && !busy_o && op_i == CBS_OP_BR_EQUAL |=>
    taken_o == $past(flags_i[FLAG_Z_POS]))
    else $error("equal branch ignored zero flag");
  // Not-equal branch follows inverted zero flag
  a_ne_cond: assert property (
    @(posedge clk_i) disable iff (rst_i)
    issue_i && !busy_o && op_i == CBS_OP_BR_NOT_EQUAL |=>
    taken_o != $past(flags_i[FLAG_Z_POS]))
    else $error("not-equal branch wrong sense");
  // Lower and carry-set agree
  a_lower_cond: assert property (
    @(posedge clk_i) disable iff (rst_i)
    issue_i && !busy_o && (op_i == CBS_OP_BR_LOWER
    || op_i == CBS_OP_BR_CARRY_SET) |=>
    taken_o == $past(flags_i[FLAG_C_POS]))
    else $error("carry set branch wrong");
  // Same-or-higher and carry-clear agree
  a_higher_cond: assert property (
    @(posedge clk_i) disable iff (rst_i)
    issue_i && !busy_o && (op_i == CBS_OP_BR_SAME_HIGHER
    || op_i == CBS_OP_BR_CARRY_CLR) |=>
    taken_o != $past(flags_i[FLAG_C_POS]))
    else $error("carry clear branch wrong");
  // Minus and plus follow negative flag
  a_minus_cond: assert property (
    @(posedge clk_i) disable iff (rst_i)
    issue_i && !busy_o && op_i == CBS_OP_BR_MINUS |=>
    taken_o == $past(flags_i[FLAG_N_POS]) && flags_o == $past(flags_i))
    else $error("minus branch wrong or flags changed");
  a_plus_cond: assert property (
    @(posedge clk_i) disable iff (rst_i)
    issue_i && !busy_o && op_i == CBS_OP_BR_PLUS |=>
    taken_o != $past(flags_i[FLAG_N_POS]))
    else $error("plus branch wrong sense");
  // Skip advances by two or three with matching cycles, then stalls
  a_skip_len: assert property (
    @(posedge clk_i) disable iff (rst_i)
    issue_i && !busy_o && op_i == CBS_OP_SKIP_IO_SET && io_bit
    |=> pc_next_o == $past(pc_i) + ($past(skip_two_word_i) ? PC_THREE
    : PC_TWO) && busy_o)
    else $error("skip length or stall wrong");
  a_skip_cycles: assert property (
    @(posedge clk_i) disable iff (rst_i)
    issue_i && !busy_o && op_i == CBS_OP_SKIP_IO_SET && io_bit
    && skip_two_word_i |=> cycles_o == CYC_THREE ##1 busy_o ##1 !busy_o)
    else $error("two-word skip cycle count wrong");
  // Short skip costs two cycles
  a_skip_short: assert property (
    @(posedge clk_i) disable iff (rst_i)
    issue_i && !busy_o && op_i == CBS_OP_SKIP_IO_SET && io_bit
    && !skip_two_word_i |=> cycles_o == CYC_TWO ##1 !busy_o)
    else $error("one-word skip cycle count wrong");
  // Bit clear means no skip, one cycle
  a_skip_none: assert property (
    @(posedge clk_i) disable iff (rst_i)
    issue_i && !busy_o && op_i == CBS_OP_SKIP_IO_SET && !io_bit |=>
    pc_next_o == $past(pc_i) + PC_ONE && cycles_o == CYC_ONE && !taken_o)
    else $error("skip taken with bit clear");
  // Issues during a stall must not load again
  a_stall_refuse: assert property (
    @(posedge clk_i) disable iff (rst_i)
    issue_i && busy_o |=> !pc_load_o)
    else $error("issue accepted during stall");
  // Offset sign extension
  a_sext_neg: assert property (
    @(posedge clk_i) disable iff (rst_i)
    issue_i && !busy_o && is_branch && taken && offset_i[K_W-1] |=>
    pc_next_o != $past(pc_i) + {{(PC_W-K_W){1'b0}}, $past(offset_i)}
    + PC_ONE)
    else $error("negative offset not sign extended");
endmodule : cbs_unit

// [design/cbs_pkg.sv]
// Package with opcodes, flag positions and cycle counts for the branch unit
package cbs_pkg;
  localparam int PC_W = 16;
  localparam int K_W = 7;
  localparam int IO_AW = 5;
  localparam int FLAG_W = 8;
  // Status flag positions
  localparam logic [2:0] FLAG_C_POS = 3'h0;
  localparam logic [2:0] FLAG_Z_POS = 3'h1;
  localparam logic [2:0] FLAG_N_POS = 3'h2;
  // Cycle counts
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;
  localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
  localparam logic [PC_W-1:0] PC_ONE = 16'h0001;
  localparam logic [PC_W-1:0] PC_TWO = 16'h0002;
  localparam logic [PC_W-1:0] PC_THREE = 16'h0003;
  // Operation codes presented on op_i
  typedef enum logic [3:0] {
    CBS_OP_NONE = 4'h0,
    CBS_OP_SKIP_IO_SET = 4'h1,
    CBS_OP_BR_SBIT_SET = 4'h2,
    CBS_OP_BR_SBIT_CLR = 4'h3,
    CBS_OP_BR_EQUAL = 4'h4,
    CBS_OP_BR_NOT_EQUAL = 4'h5,
    CBS_OP_BR_CARRY_SET = 4'h6,
    CBS_OP_BR_CARRY_CLR = 4'h7,
    CBS_OP_BR_SAME_HIGHER = 4'h8,
    CBS_OP_BR_LOWER = 4'h9,
    CBS_OP_BR_MINUS = 4'ha,
    CBS_OP_BR_PLUS = 4'hb
  } cbs_op_t;
endpackage : cbs_pkg

// [design/cbs_cond_eval.sv]
// Condition evaluator: decides whether a branch or skip is taken
module cbs_cond_eval
  import cbs_pkg::*;
(
  // Operation and operands
  input wire cbs_op_t op_i,
  input wire logic [2:0] sel_i,
  input wire logic [FLAG_W-1:0] flags_i,
  input wire logic io_bit_i,
  // Decision
  output logic taken_o,
  output logic is_branch_o
);
  // Flag test, set sense or clear sense
  always_comb begin
    taken_o = 1'b0;
    is_branch_o = 1'b1;
    unique case (op_i)
      CBS_OP_SKIP_IO_SET: begin
        is_branch_o = 1'b0;
        taken_o = io_bit_i;
      end
      CBS_OP_BR_SBIT_SET: taken_o = flags_i[sel_i];
      CBS_OP_BR_SBIT_CLR: taken_o = !flags_i[sel_i];
      CBS_OP_BR_EQUAL: taken_o = flags_i[FLAG_Z_POS];
      CBS_OP_BR_NOT_EQUAL: taken_o = !flags_i[FLAG_Z_POS];
      CBS_OP_BR_CARRY_SET,
      CBS_OP_BR_LOWER: taken_o = flags_i[FLAG_C_POS];
      CBS_OP_BR_CARRY_CLR,
      CBS_OP_BR_SAME_HIGHER: taken_o = !flags_i[FLAG_C_POS];
      CBS_OP_BR_MINUS: taken_o = flags_i[FLAG_N_POS];
      CBS_OP_BR_PLUS: taken_o = !flags_i[FLAG_N_POS];
      default: is_branch_o = 1'b0;
    endcase
  end
endmodule : cbs_cond_eval

// [tb/cbs_unit_tb_top.sv]
// Self-checking testbench for the branch and skip unit
module cbs_unit_tb_top
  import cbs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Inputs, all set at time zero
  logic clk_i = 1'b0, rst_i = 1'b1, issue_i = 1'b0, skip_two_word_i = 1'b0;
  cbs_op_t op_i = CBS_OP_NONE;
  logic [2:0] sel_i = 3'h0, io_bit_sel_i = 3'h0;
  logic [K_W-1:0] offset_i = 7'h0;
  logic [IO_AW-1:0] io_addr_i = 5'h0, io_addr_o;
  logic [PC_W-1:0] pc_i = 16'h0, pc_next_o;
  logic [FLAG_W-1:0] flags_i = 8'h0, io_data_i = 8'h0, flags_o;
  logic pc_load_o, taken_o, busy_o;
  logic [1:0] cycles_o;
  int n_mismatch = 0, checks = 0;
  // Unit under test and its 100 MHz clock
  cbs_unit cbs_unit_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .issue_i(issue_i),
    .op_i(op_i),
    .sel_i(sel_i),
    .offset_i(offset_i),
    .io_addr_i(io_addr_i),
    .skip_two_word_i(skip_two_word_i),
    .pc_i(pc_i),
    .flags_i(flags_i),
    .io_data_i(io_data_i),
    .io_bit_sel_i(io_bit_sel_i),
    .pc_next_o(pc_next_o),
    .pc_load_o(pc_load_o),
    .cycles_o(cycles_o),
    .taken_o(taken_o),
    .busy_o(busy_o),
    .io_addr_o(io_addr_o),
    .flags_o(flags_o)
  );
  initial forever #5 clk_i = ~clk_i;
  // Compare one value and count it
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One issue and its stall; hold keeps issue up, it must be ignored
  task automatic go(cbs_op_t op, logic [7:0] fl, logic [2:0] s,
    logic [6:0] k, logic [15:0] pc, logic tk, logic sk2 = 1'b0,
    logic [7:0] iod = 8'h0, logic hold = 1'b0);
    logic [1:0] ec;
    logic [15:0] ep;
    ec = !tk ? CYC_ONE : sk2 ? CYC_THREE : CYC_TWO;
    ep = !tk ? pc + PC_ONE : (op == CBS_OP_SKIP_IO_SET) ? pc + 16'(ec)
      : pc + {{9{k[6]}}, k} + PC_ONE;
    @(posedge clk_i);
    #1 issue_i = 1'b1;
    op_i = op;
    sel_i = s;
    io_bit_sel_i = s;
    offset_i = k;
    skip_two_word_i = sk2;
    io_data_i = iod;
    pc_i = pc;
    flags_i = fl;
    io_addr_i = pc[4:0] ^ 5'h15;
    @(posedge clk_i);
    #1 issue_i = hold;
    chk("pc_load", pc_load_o, 1);
    chk("tk_cyc", {taken_o, cycles_o}, {tk, ec});
    chk("pc_next", pc_next_o, ep);
    chk("flags_io", {io_addr_o, flags_o}, {io_addr_i, fl});
    // Stall of cycles minus one, no second load meanwhile
    for (int i = 1; i < ec; i++) begin
      chk("busy", busy_o, 1);
      @(posedge clk_i);
      #1 issue_i = 1'b0;
      chk("pc_load_end", pc_load_o, 0);
    end
    chk("busy_end", {busy_o, pc_next_o}, {1'b0, ep});
  endtask : go
  // Results other than io_addr_o all clear out of reset
  task automatic t_reset();
    chk("reset", {pc_load_o, taken_o, busy_o, cycles_o, pc_next_o, flags_o},
      {PC_RESET, 8'h0});
  endtask : t_reset
  // Each flag branch with its flag set and clear, then far offsets
  task automatic t_flags();
    logic [2:0] pos[8] = '{1, 1, 0, 0, 0, 0, 2, 2};
    logic [7:0] pol = 8'h65, m;
    cbs_op_t op;
    for (int i = 0; i < 8; i++) begin
      m = 8'h01 << pos[i];
      op = cbs_op_t'(i + 4);
      go(op, m, 3'h0, 7'h7e, 16'h10, pol[i]);
      go(op, ~m, 3'h0, 7'h5, 16'h10, !pol[i]);
    end
    op = CBS_OP_BR_MINUS;
    go(op, 8'h4, 3'h0, 7'h40, 16'h20, 1'b1);
    go(CBS_OP_BR_PLUS, 8'h0, 3'h0, 7'h3f, 16'hfff0, 1'b1);
  endtask : t_flags
  // Status bit branches over every bit, bit set and bit clear
  task automatic t_status();
    logic [7:0] m;
    logic [2:0] b;
    for (int j = 0; j < 16; j++) begin
      b = j[2:0];
      m = (8'h01 << b) ^ {8{j[3]}};
      go(CBS_OP_BR_SBIT_SET, m, b, 7'h3, 16'h40, m[b]);
      go(CBS_OP_BR_SBIT_CLR, m, b, 7'h7d, 16'h40, !m[b]);
    end
  endtask : t_status
  // Skips of one and two words, bit clear, and issues during a stall
  task automatic t_skip();
    cbs_op_t op = CBS_OP_SKIP_IO_SET;
    logic [7:0] m;
    for (int b = 0; b < 8; b++) begin
      m = 8'h01 << b;
      go(op, 8'h55, 3'(b), 7'h0, 16'h80, 1'b1, 1'b0, m);
      go(op, 8'h55, 3'(b), 7'h0, 16'h80, 1'b1, 1'b1, m);
      go(op, 8'h55, 3'(b), 7'h0, 16'h80, 1'b0, 1'b1, ~m);
    end
    go(op, 8'h2, 3'h3, 7'h7e, 16'hc0, 1'b1, 1'b1, 8'h8, 1'b1);
    op = CBS_OP_BR_EQUAL;
    go(op, 8'h2, 3'h0, 7'h7e, 16'hc0, 1'b1, 1'b0, 8'h0, 1'b1);
  endtask : t_skip
  // Verdict, from the main sequence or the watchdog
  task automatic end_of_test();
    if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  // Watchdog: the scenarios need well under a thousand cycles
  initial begin
    #100000 n_mismatch++;
    end_of_test();
  end
  // Reset for five cycles, then the scenarios
  initial begin
    repeat (5) @(posedge clk_i);
    #1 rst_i = 1'b0;
    t_reset();
    t_flags();
    t_status();
    t_skip();
    end_of_test();
  end
endmodule : cbs_unit_tb_top
